// >>> hdl/dcf_pkg.sv
// Purpose: constants shared by the two-clock-style fifo flag and retransmit block
// Assumes: one clock drives both ports; offsets come from plain ports
// Notes:   pointers carry one wrap bit above the memory index

package dcf_pkg;
   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int          DATA_W      = 36;
   localparam int          ADDR_W      = 9;
   localparam int          PTR_W       = 10;
   localparam int          OFF_W       = 9;
   localparam int          MEM_DEPTH   = 512;
   localparam int          STAGE_DEPTH = 32;
   localparam logic [9:0]  DEPTH_CNT   = 10'h200;
   localparam logic [9:0]  PTR_ZERO    = 10'h000;
   localparam logic [9:0]  PTR_ONE     = 10'h001;
   // ------------------------------------------------------------
   // offsets and retransmit
   // ------------------------------------------------------------
   localparam logic [8:0]  OFF_MIN     = 9'h001;
   localparam logic [8:0]  OFF_MAX     = 9'h1fc;
   localparam logic [9:0]  RT_MIN_GAP  = 10'h003;
   localparam logic [35:0] DATA_ZERO   = 36'h0;
endpackage : dcf_pkg

// >>> hdl/dcf_stage_if.sv
// Purpose: valid/ready carrier between the block and its staging fifo
// Assumes: single clock
// Notes:   fifo modport faces the buffer, user modport faces the block
`timescale 1ns/1ps
`default_nettype none

interface dcf_stage_if #(parameter int WIDTH = dcf_pkg::DATA_W);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;

   modport fifo (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
   modport user (output in_valid, output in_data, output out_ready,
                 input in_ready, input out_valid, input out_data);
endinterface : dcf_stage_if

`default_nettype wire

// >>> hdl/dcf_stage_fifo.sv
// Purpose: staging buffer between write port and the main array
// Assumes: in_valid only taken while in_ready high
// Notes:   honest full and empty from an occupancy count
`timescale 1ns/1ps
`default_nettype none

module dcf_stage_fifo #(
   parameter int WIDTH = dcf_pkg::DATA_W,
   parameter int DEPTH = dcf_pkg::STAGE_DEPTH
) (
   // clock and reset
   input  wire logic  clk_i,
   input  wire logic  rst_n_i,
   // buffer ports
   dcf_stage_if.fifo  stage
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp;
   logic [AW:0]      rp;
   logic [AW:0]      cnt;
   logic [AW:0]      next_wp;
   logic [AW:0]      next_rp;
   logic [AW:0]      next_cnt;
   logic             push;
   logic             pop;

   // ------------------------------------------------------------
   // flags
   // ------------------------------------------------------------
   assign stage.in_ready  = (cnt != CNT_FULL);
   assign stage.out_valid = (cnt != '0);
   assign stage.out_data  = mem[rp[AW-1:0]];

   always_comb begin
      push     = stage.in_valid & stage.in_ready;
      pop      = stage.out_valid & stage.out_ready;
      next_wp  = push ? wp + 1'b1 : wp;
      next_rp  = pop ? rp + 1'b1 : rp;
      next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         wp  <= next_wp;
         rp  <= next_rp;
         cnt <= next_cnt;
      end
   end

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp[AW-1:0]] <= stage.in_data;
      end
   end
endmodule : dcf_stage_fifo

`default_nettype wire

// >>> hdl/dcf_flags_retransmit.sv
// Purpose: 512x36 fifo with ready/almost flags and synchronous retransmit
// Assumes: both ports and offset inputs live on clk_i
// Notes:   flag latencies follow two-stage pointer pipelines
`timescale 1ns/1ps
`default_nettype none

module dcf_flags_retransmit (
   // clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   // write port
   input  wire logic                       write_side_chip_select_n_i,
   input  wire logic                       write_side_direction_i,
   input  wire logic                       write_side_enable_i,
   input  wire logic                       write_side_mail_select_i,
   input  wire logic [dcf_pkg::DATA_W-1:0] write_data_i,
   // read port
   input  wire logic                       read_side_chip_select_n_i,
   input  wire logic                       read_side_direction_i,
   input  wire logic                       read_side_enable_i,
   input  wire logic                       read_side_mail_select_i,
   input  wire logic                       retransmit_mode_select_i,
   input  wire logic                       reread_from_marker_i,
   // offsets
   input  wire logic [dcf_pkg::OFF_W-1:0]  empty_offset_i,
   input  wire logic [dcf_pkg::OFF_W-1:0]  full_offset_i,
   // read-side status
   output logic [dcf_pkg::DATA_W-1:0]      read_data_o,
   output logic                            output_ready_o,
   output logic                            almost_empty_n_o,
   output logic                            retransmit_active_o,
   // write-side status
   output logic                            input_ready_flag_o,
   output logic                            almost_full_n_o
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [dcf_pkg::OFF_W-1:0] clamp_offset(
      input logic [dcf_pkg::OFF_W-1:0] v);
      logic [dcf_pkg::OFF_W-1:0] r;
      r = v;
      if (v < dcf_pkg::OFF_MIN) begin
         r = dcf_pkg::OFF_MIN;
      end else if (v > dcf_pkg::OFF_MAX) begin
         r = dcf_pkg::OFF_MAX;
      end
      return r;
   endfunction : clamp_offset

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [dcf_pkg::DATA_W-1:0] mem [dcf_pkg::MEM_DEPTH];

   logic [dcf_pkg::PTR_W-1:0]  wptr;
   logic [dcf_pkg::PTR_W-1:0]  next_wptr;
   logic                       mem_push;
   logic                       mem_room;

   logic [dcf_pkg::PTR_W-1:0]  rptr;
   logic [dcf_pkg::PTR_W-1:0]  wptr_seen;
   logic [dcf_pkg::PTR_W-1:0]  shadow;
   logic [dcf_pkg::DATA_W-1:0] rdata;
   logic                       oready;
   logic                       rt_mode;
   logic                       ae_n;
   logic [dcf_pkg::OFF_W-1:0]  x_off;
   logic [dcf_pkg::PTR_W-1:0]  next_rptr;
   logic [dcf_pkg::PTR_W-1:0]  next_wptr_seen;
   logic [dcf_pkg::PTR_W-1:0]  next_shadow;
   logic [dcf_pkg::DATA_W-1:0] next_rdata;
   logic                       next_oready;
   logic                       next_rt_mode;
   logic                       next_ae_n;
   logic [dcf_pkg::OFF_W-1:0]  next_x_off;
   logic                       rd_fire;
   logic                       rt_fire;
   logic                       word_avail;

   logic [dcf_pkg::PTR_W-1:0]  wacc;
   logic [dcf_pkg::PTR_W-1:0]  rp_flag;
   logic                       iready;
   logic                       af_n;
   logic [dcf_pkg::OFF_W-1:0]  y_off;
   logic [dcf_pkg::PTR_W-1:0]  next_wacc;
   logic [dcf_pkg::PTR_W-1:0]  next_rp_flag;
   logic                       next_iready;
   logic                       next_af_n;
   logic [dcf_pkg::OFF_W-1:0]  next_y_off;
   logic [dcf_pkg::PTR_W-1:0]  rp_hold;
   logic [dcf_pkg::PTR_W-1:0]  fill_w;
   logic [dcf_pkg::PTR_W-1:0]  af_level;
   logic                       wr_fire;

   dcf_stage_if #(.WIDTH(dcf_pkg::DATA_W)) stage ();

   // ------------------------------------------------------------
   // write port into staging buffer
   // ------------------------------------------------------------
   always_comb begin
      wr_fire = ~write_side_chip_select_n_i & ~write_side_mail_select_i
              & write_side_direction_i & write_side_enable_i
              & iready & stage.in_ready;
   end

   assign stage.in_valid  = wr_fire;
   assign stage.in_data   = write_data_i;
   assign stage.out_ready = mem_room;

   dcf_stage_fifo #(
      .WIDTH (dcf_pkg::DATA_W),
      .DEPTH (dcf_pkg::STAGE_DEPTH)
   ) u_stage (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .stage   (stage)
   );

   // ------------------------------------------------------------
   // main array write pointer
   // ------------------------------------------------------------
   always_comb begin
      rp_hold   = rt_mode ? shadow : rptr;
      mem_room  = ((wptr - rp_hold) != dcf_pkg::DEPTH_CNT);
      mem_push  = stage.out_valid & mem_room;
      next_wptr = mem_push ? wptr + dcf_pkg::PTR_ONE : wptr;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wptr <= dcf_pkg::PTR_ZERO;
      end else begin
         wptr <= next_wptr;
      end
   end

   always_ff @(posedge clk_i) begin
      if (mem_push) begin
         mem[wptr[dcf_pkg::ADDR_W-1:0]] <= stage.out_data;
      end
   end

   // ------------------------------------------------------------
   // read side: output register, retransmit, almost-empty
   // ------------------------------------------------------------
   always_comb begin
      next_rptr      = rptr;
      next_rdata     = rdata;
      next_oready    = oready;
      next_rt_mode   = rt_mode;
      next_shadow    = shadow;
      next_wptr_seen = wptr;
      next_x_off     = clamp_offset(empty_offset_i);
      word_avail     = (wptr_seen != rptr);
      rd_fire = ~read_side_chip_select_n_i & ~read_side_mail_select_i
              & read_side_direction_i & read_side_enable_i & oready;
      rt_fire = rt_mode & reread_from_marker_i
              & ((rptr - shadow) >= dcf_pkg::RT_MIN_GAP);
      if (rt_fire) begin
         next_rdata  = mem[shadow[dcf_pkg::ADDR_W-1:0]];
         next_rptr   = shadow + dcf_pkg::PTR_ONE;
         next_oready = 1'b1;
      end else if ((~oready | rd_fire) & word_avail) begin
         next_rdata  = mem[rptr[dcf_pkg::ADDR_W-1:0]];
         next_rptr   = rptr + dcf_pkg::PTR_ONE;
         next_oready = 1'b1;
      end else if (rd_fire) begin
         next_oready = 1'b0;
      end
      if (!rt_mode && retransmit_mode_select_i && oready) begin
         next_rt_mode = 1'b1;
         next_shadow  = rptr - dcf_pkg::PTR_ONE;
      end else if (rt_mode && !retransmit_mode_select_i) begin
         next_rt_mode = 1'b0;
      end
      next_ae_n = ((wptr - rptr) > {1'b0, x_off});
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rptr      <= dcf_pkg::PTR_ZERO;
         wptr_seen <= dcf_pkg::PTR_ZERO;
         shadow    <= dcf_pkg::PTR_ZERO;
         rdata     <= dcf_pkg::DATA_ZERO;
         oready    <= 1'b0;
         rt_mode   <= 1'b0;
         ae_n      <= 1'b0;
         x_off     <= dcf_pkg::OFF_MIN;
      end else begin
         rptr      <= next_rptr;
         wptr_seen <= next_wptr_seen;
         shadow    <= next_shadow;
         rdata     <= next_rdata;
         oready    <= next_oready;
         rt_mode   <= next_rt_mode;
         ae_n      <= next_ae_n;
         x_off     <= next_x_off;
      end
   end

   // ------------------------------------------------------------
   // write side: input-ready and almost-full
   // ------------------------------------------------------------
   always_comb begin
      next_wacc    = wr_fire ? wacc + dcf_pkg::PTR_ONE : wacc;
      next_rp_flag = rp_hold;
      next_y_off   = clamp_offset(full_offset_i);
      fill_w       = next_wacc - rp_flag;
      af_level     = dcf_pkg::DEPTH_CNT - {1'b0, y_off};
      next_iready  = (fill_w != dcf_pkg::DEPTH_CNT);
      next_af_n    = (fill_w < af_level);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wacc    <= dcf_pkg::PTR_ZERO;
         rp_flag <= dcf_pkg::PTR_ZERO;
         iready  <= 1'b0;
         af_n    <= 1'b1;
         y_off   <= dcf_pkg::OFF_MIN;
      end else begin
         wacc    <= next_wacc;
         rp_flag <= next_rp_flag;
         iready  <= next_iready;
         af_n    <= next_af_n;
         y_off   <= next_y_off;
      end
   end

   // ------------------------------------------------------------
   // outputs, all straight from flip-flops
   // ------------------------------------------------------------
   assign read_data_o         = rdata;
   assign output_ready_o      = oready;
   assign almost_empty_n_o    = ae_n;
   assign retransmit_active_o = rt_mode;
   assign input_ready_flag_o  = iready;
   assign almost_full_n_o     = af_n;

endmodule : dcf_flags_retransmit

`default_nettype wire

// >>> bench/dcf_flags_retransmit_assertions.sv
// Purpose: concurrent checks on the flag and retransmit block ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none

module dcf_flags_assertions (
   // clock and reset
   input wire logic                       clk_i,
   input wire logic                       rst_n_i,
   // port controls
   input wire logic                       write_side_chip_select_n_i,
   input wire logic                       write_side_direction_i,
   input wire logic                       write_side_enable_i,
   input wire logic                       write_side_mail_select_i,
   input wire logic                       read_side_chip_select_n_i,
   input wire logic                       read_side_direction_i,
   input wire logic                       read_side_enable_i,
   input wire logic                       read_side_mail_select_i,
   input wire logic                       retransmit_mode_select_i,
   input wire logic                       reread_from_marker_i,
   // status
   input wire logic [dcf_pkg::DATA_W-1:0] read_data_o,
   input wire logic                       output_ready_o,
   input wire logic                       almost_empty_n_o,
   input wire logic                       retransmit_active_o,
   input wire logic                       input_ready_flag_o,
   input wire logic                       almost_full_n_o
);
   logic wr_take;
   logic rd_take;

   assign wr_take = ~write_side_chip_select_n_i & ~write_side_mail_select_i
                    & write_side_direction_i & write_side_enable_i & input_ready_flag_o;
   assign rd_take = ~read_side_chip_select_n_i & ~read_side_mail_select_i
                    & read_side_direction_i & read_side_enable_i & output_ready_o;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // ---------------------------------------------
   // read side
   // ---------------------------------------------
   or_hold_a:
      assert property (!output_ready_o ##1 !output_ready_o |-> $stable(read_data_o))
      else $error("output word changed while not ready");
   or_fill_a:
      assert property (wr_take && !output_ready_o && !retransmit_active_o && !$past(wr_take)
         && !$past(wr_take, 2) && !$past(wr_take, 3) |=> !output_ready_o [*3] ##1 output_ready_o)
      else $error("first word latency wrong");
   ae_rise_a:
      assert property ($rose(almost_empty_n_o) |-> $past(wr_take, 3) || retransmit_active_o
         || $past(retransmit_active_o, 3))
      else $error("almost empty rose without cause");
   rt_enter_a:
      assert property (retransmit_mode_select_i && output_ready_o |=> retransmit_active_o)
      else $error("retransmit mode not entered");
   rt_leave_a:
      assert property (!retransmit_mode_select_i |=> !retransmit_active_o)
      else $error("retransmit mode not left");

   // ---------------------------------------------
   // write side
   // ---------------------------------------------
   ir_rise_a:
      assert property ($rose(input_ready_flag_o) |-> $past(rd_take, 3)
         || $past(retransmit_active_o, 3) || !$past(rst_n_i, 2))
      else $error("input ready rose without cause");
   af_rise_a:
      assert property ($rose(almost_full_n_o) |-> $past(rd_take, 3)
         || $past(retransmit_active_o, 3))
      else $error("almost full rose without cause");
   af_fall_a:
      assert property ($fell(almost_full_n_o) |-> $past(wr_take))
      else $error("almost full fell without a write");
   full_order_a:
      assert property ($fell(input_ready_flag_o) |-> !almost_full_n_o)
      else $error("full without almost full");

   cover property (retransmit_active_o && reread_from_marker_i);
   cover property ($fell(input_ready_flag_o));
   cover property ($rose(almost_empty_n_o));
endmodule : dcf_flags_assertions

bind dcf_flags_retransmit dcf_flags_assertions u_flags_chk (.*);

`default_nettype wire

// >>> bench/dcf_reader_model.sv
// Purpose: reader on the read port, drains words and tallies them
// Assumes: words were written as 1, 2, 3 ... from reset
// Notes:   slow mode idles one cycle after every taken word
`timescale 1ns/1ps
`default_nettype none

module dcf_reader_model (
   // clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   // bench control
   input  wire logic                       run_i,
   input  wire logic                       slow_i,
   // read port
   input  wire logic                       output_ready_i,
   input  wire logic [dcf_pkg::DATA_W-1:0] read_data_i,
   output logic                            cs_n_o,
   output logic                            dir_o,
   output logic                            en_o,
   output logic                            mail_o,
   // tally
   output logic [15:0]                     cnt_o,
   output logic [15:0]                     bad_o
);
   logic gap;

   assign cs_n_o = 1'b0;
   assign dir_o  = 1'b1;
   assign mail_o = 1'b0;
   // request follows run, dropping for one cycle after a taken word in slow mode
   assign en_o   = run_i & ~gap;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap   <= 1'b0;
         cnt_o <= 16'h0000;
         bad_o <= 16'h0000;
      end else begin
         gap <= slow_i & en_o & output_ready_i;
         if (en_o && output_ready_i) begin
            cnt_o <= cnt_o + 16'h0001;
            if (read_data_i !== 36'(cnt_o + 16'h0001)) begin
               bad_o <= bad_o + 16'h0001;
            end
         end
      end
   end
endmodule : dcf_reader_model

`default_nettype wire

// >>> bench/tb_dual_clock_fifo_flags_retransmit.sv
// Purpose: self-checking bench for the flag and retransmit block
// Assumes: empty offset 4 (508 after clamping in the last scenario), full offset 8
// Notes:   write data counts up so order is checked by the reader
`timescale 1ns/1ps
`default_nettype none

module tb_dual_clock_fifo_flags_retransmit;
   logic                       clk_i, rst_n_i;
   logic                       write_side_chip_select_n_i, write_side_direction_i;
   logic                       write_side_enable_i, write_side_mail_select_i;
   logic [dcf_pkg::DATA_W-1:0] write_data_i, read_data_o;
   logic                       read_side_chip_select_n_i, read_side_direction_i;
   logic                       read_side_enable_i, read_side_mail_select_i;
   logic                       retransmit_mode_select_i, reread_from_marker_i;
   logic [dcf_pkg::OFF_W-1:0]  empty_offset_i, full_offset_i;
   logic                       output_ready_o, almost_empty_n_o, retransmit_active_o;
   logic                       input_ready_flag_o, almost_full_n_o, run, slow;
   logic [15:0]                rd_cnt, rd_bad;
   int                         n_mismatch, n_compared;

   dcf_flags_retransmit DUT (.*);
   dcf_reader_model reader (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run), .slow_i(slow),
      .output_ready_i(output_ready_o), .read_data_i(read_data_o),
      .cs_n_o(read_side_chip_select_n_i), .dir_o(read_side_direction_i),
      .en_o(read_side_enable_i), .mail_o(read_side_mail_select_i),
      .cnt_o(rd_cnt), .bad_o(rd_bad));

   task automatic chk_w(input logic [35:0] got, input logic [35:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk_w

   task automatic chk_f(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_f

   task automatic end_of_test;
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   // zero waits for output ready, otherwise for that reader count
   task automatic wait_for(input logic [15:0] cnt);
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk_i);
         #1;
         if (cnt == 16'h0 ? output_ready_o === 1'b1 : rd_cnt === cnt) return;
      end
      n_mismatch++;
      $display("[ERR] %0t wait expired", $time);
      end_of_test();
   endtask : wait_for

   task automatic t_reset;
      #1;
      chk_f(output_ready_o, 1'b0);
      chk_f(input_ready_flag_o, 1'b0);
      chk_f(almost_empty_n_o, 1'b0);
      chk_f(almost_full_n_o, 1'b1);
      chk_f(retransmit_active_o, 1'b0);
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      chk_f(input_ready_flag_o, 1'b1);
   endtask : t_reset

   // fill past full with two refused writes, then drain slowly
   task automatic t_fill;
      @(posedge clk_i);
      write_side_enable_i <= 1'b1;
      write_data_i        <= 36'h1;
      for (int n = 1; n <= 514; n++) begin
         @(posedge clk_i);
         write_data_i <= 36'(n + 1);
         #1;
         chk_f(input_ready_flag_o, n < 513);
         chk_f(almost_full_n_o, n < 505);
         chk_f(almost_empty_n_o, n >= 8);
         chk_f(output_ready_o, n >= 4);
         chk_w(read_data_o, 36'(n >= 4));
      end
      @(posedge clk_i);
      write_side_enable_i <= 1'b0;
      slow                <= 1'b1;
      run                 <= 1'b1;
      wait_for(16'h201);
      chk_w(36'(rd_bad), 36'h0);
      repeat (8) @(posedge clk_i);
      #1;
      chk_w(36'(rd_cnt), 36'h201);
      chk_f(output_ready_o, 1'b0);
      chk_f(almost_empty_n_o, 1'b0);
      chk_f(input_ready_flag_o, 1'b1);
      chk_f(almost_full_n_o, 1'b1);
      @(posedge clk_i);
      run  <= 1'b0;
      slow <= 1'b0;
   endtask : t_fill

   // mailbox write is not stored, then mark, two reads, reread, exit
   task automatic t_rtx;
      @(posedge clk_i);
      write_side_mail_select_i <= 1'b1;
      write_side_enable_i      <= 1'b1;
      write_data_i             <= 36'h63;
      for (int k = 0; k < 6; k++) begin
         @(posedge clk_i);
         write_side_mail_select_i <= 1'b0;
         write_data_i             <= 36'(8'h64 + k);
      end
      @(posedge clk_i);
      write_side_enable_i <= 1'b0;
      wait_for(16'h0);
      chk_w(read_data_o, 36'h64);
      @(posedge clk_i);
      retransmit_mode_select_i <= 1'b1;
      @(posedge clk_i);
      run <= 1'b1;
      #1;
      chk_f(retransmit_active_o, 1'b1);
      repeat (2) @(posedge clk_i);
      run                  <= 1'b0;
      reread_from_marker_i <= 1'b1;
      #1;
      chk_w(read_data_o, 36'h66);
      @(posedge clk_i);
      run                      <= 1'b1;
      reread_from_marker_i     <= 1'b0;
      retransmit_mode_select_i <= 1'b0;
      #1;
      chk_w(read_data_o, 36'h64);
      chk_f(output_ready_o, 1'b1);
      @(posedge clk_i);
      run <= 1'b0;
      #1;
      chk_w(read_data_o, 36'h65);
      chk_f(retransmit_active_o, 1'b0);
   endtask : t_rtx

   // mark on a read edge, fill against the shadow pointer, then leave the mode
   task automatic t_rtfull;
      @(posedge clk_i);
      retransmit_mode_select_i <= 1'b1;
      run                      <= 1'b1;
      empty_offset_i           <= 9'h1ff;
      repeat (2) @(posedge clk_i);
      run                 <= 1'b0;
      write_side_enable_i <= 1'b1;
      #1;
      chk_w(read_data_o, 36'h67);
      chk_f(retransmit_active_o, 1'b1);
      for (int n = 1; n <= 508; n++) begin
         @(posedge clk_i);
         #1;
         chk_f(input_ready_flag_o, n < 507);
         chk_f(almost_full_n_o, n < 499);
      end
      @(posedge clk_i);
      write_side_enable_i      <= 1'b0;
      retransmit_mode_select_i <= 1'b0;
      for (int e = 0; e < 3; e++) begin
         @(posedge clk_i);
         #1;
         chk_f(input_ready_flag_o, e == 2);
      end
      chk_f(retransmit_active_o, 1'b0);
      chk_f(almost_full_n_o, 1'b0);
      chk_f(almost_empty_n_o, 1'b1);
   endtask : t_rtfull

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   initial begin
      rst_n_i                    = 1'b0;
      write_side_chip_select_n_i = 1'b0;
      write_side_direction_i     = 1'b1;
      write_side_enable_i        = 1'b0;
      write_side_mail_select_i   = 1'b0;
      write_data_i               = 36'h0;
      retransmit_mode_select_i   = 1'b0;
      reread_from_marker_i       = 1'b0;
      empty_offset_i             = 9'h004;
      full_offset_i              = 9'h008;
      run                        = 1'b0;
      slow                       = 1'b0;
      n_mismatch                 = 0;
      n_compared                 = 0;
      repeat (20) @(posedge clk_i);
      t_reset();
      t_fill();
      t_rtx();
      t_rtfull();
      end_of_test();
   end
endmodule : tb_dual_clock_fifo_flags_retransmit

`default_nettype wire
